// ==== design/ppc_pkg.sv ====
// Register indices, field positions, codes and states of the parallel port controller
package ppc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [13:0] IDX_PAD_HIGH = 14'h0f57;
	localparam logic [13:0] IDX_WAIT = 14'h0f5c;
	localparam logic [13:0] IDX_MODE = 14'h0f5d;
	localparam logic [13:0] IDX_POL = 14'h0f5e;
	localparam logic [13:0] IDX_MAIN = 14'h0f5f;
	localparam logic [13:0] IDX_DATA = 14'h0f60;
	localparam logic [13:0] IDX_ADDR = 14'h0f61;
	localparam logic [7:0] RESET_VAL = 8'h00;
	// Main control fields
	localparam int MAIN_ON = 7;
	localparam int MAIN_IDLE = 5;
	localparam int MAIN_MUX = 3;
	localparam int MAIN_BE_ON = 2;
	localparam int MAIN_WR_ON = 1;
	localparam int MAIN_RD_ON = 0;
	localparam logic [7:0] MAIN_WMASK = 8'hbf;
	// Polarity control fields
	localparam int POL_CSF = 6;
	localparam int POL_AL = 5;
	localparam int POL_CS = 3;
	localparam int POL_BE = 2;
	localparam int POL_WR = 1;
	localparam int POL_RD = 0;
	localparam logic [7:0] POL_WMASK = 8'hef;
	// Mode fields
	localparam int MODE_BUSY = 7;
	localparam int MODE_IRQ = 5;
	localparam int MODE_STEP = 3;
	localparam int MODE_WIDE = 2;
	localparam int MODE_SEL = 0;
	localparam logic [7:0] MODE_WMASK = 8'h7f;
	// Wait fields
	localparam int WAIT_SETUP = 6;
	localparam int WAIT_STROBE = 2;
	localparam int WAIT_HOLD = 0;
	// Codes
	localparam logic [1:0] MODE_LEGACY = 2'h0;
	localparam logic [1:0] MODE_ENH = 2'h1;
	localparam logic [1:0] MODE_MASTER2 = 2'h2;
	localparam logic [1:0] MODE_MASTER1 = 2'h3;
	localparam logic [1:0] MUX_SEP = 2'h0;
	localparam logic [1:0] MUX_FULL = 2'h2;
	localparam logic [1:0] CSF_ON = 2'h2;
	localparam logic [1:0] IRQ_BUF3 = 2'h3;
	localparam logic [1:0] IRQ_STALL = 2'h2;
	localparam logic [1:0] IRQ_EACH = 2'h1;
	localparam logic [1:0] STEP_INC = 2'h1;
	localparam logic [1:0] STEP_DEC = 2'h2;
	localparam logic [1:0] STEP_BUF = 2'h3;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam logic [1:0] BUF_LAST = 2'h3;
	typedef enum logic [2:0] {
		PPC_IDLE, PPC_ADDR_LO, PPC_ADDR_HI, PPC_SETUP, PPC_STROBE, PPC_HOLD
	} ppc_state_t;
endpackage

// ==== design/ppc_port_ctrl.sv ====
// Parallel master/slave port: control registers, transfer sequencer and pad drive
//
// Contract
// RULE1: Module enable clear disables the port; no off-chip access happens.
// RULE2: Stop-in-idle set halts the module while the processor idles.
// RULE3: Mux code 10 all address on data pins, 01 low byte, 00 separate.
// RULE4: Byte-enable, write and read strobe pins connect only when their enable is set.
// RULE5: Chip-select code 10 drives chip select, address limited; 00 full address.
// RULE6: Latch, chip-select and byte-enable polarity bits: set means active-high.
// RULE7: Mode 11 polarity bits apply to enable and read/write strobes instead.
// RULE8: Latch and chip-select polarity ignored when those pins carry address.
// RULE9: Read-only busy flag shows a master transfer in progress.
// RULE10: Interrupt code 11 fires on buffer 3 or slave address 3 access.
// RULE11: Interrupt code 10 stalls processor, 01 interrupts each cycle, 00 nothing.
// RULE12: Step code 01 increments, 10 decrements address bits 15,13:0 per cycle.
// RULE13: Step code 11 in legacy slave mode auto-advances the slave buffers.
// RULE14: Wide mode makes each data register access two byte transfers.
// RULE15: Mode 11 master 1, 10 master 2, 01 enhanced slave, 00 legacy slave.
// RULE16: Setup wait gives 1 to 4 cycles of data setup and address phase.
// RULE17: Strobe wait adds 0 to 15 cycles; zero forces a one-cycle strobe.
// RULE18: Hold wait keeps data 1 to 4 cycles after the strobe.
// RULE19: Strobe wait zero makes setup and hold waits ignored.
// RULE20: Pad enables route pads 15:14 and 13:8 to the port, else general I/O.
// RULE21: All control fields reset to zero: disabled legacy slave, pads general I/O.
// RULE22: Unimplemented control bits read zero and are kept zero.
// RULE23: Legacy slave write with chip select captures data pins into input buffer one.
// RULE24: Configuration is taken at transfer start; later changes affect later transfers. Polarity bits and pin enables are not latched and act at once.
`timescale 1ns/100ps
module ppc_port_ctrl (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cpuIdle,
	input wire logic [7:0] portDataPinsIn,
	output logic [7:0] portDataPinsOut,
	output logic portDataPinsOe,
	output logic [7:0] portAddressPinsOut,
	output logic [7:0] portAddressPinsOe,
	input wire logic [1:0] slaveAddrIn,
	input wire logic chipSelectIn,
	input wire logic writeStrobeIn,
	output logic writeStrobeOut,
	output logic writeStrobeOe,
	input wire logic readStrobeIn,
	output logic readStrobeOut,
	output logic readStrobeOe,
	output logic byteEnableOut,
	output logic byteEnableOe,
	output logic addrLatchLowStrobe,
	output logic addrLatchHighStrobe,
	output logic portIrq,
	output logic cpuStall
);
	typedef struct packed {
		logic [7:0] mainCtl;
		logic [7:0] polCtl;
		logic [7:0] modeCfg;
		logic [7:0] waitCfg;
		logic [7:0] padEn;
		logic [15:0] addr;
		logic [15:0] dataOut;
		logic [15:0] dataIn;
		logic [3:0][7:0] inBuf;
		logic [3:0] inFull;
		logic [1:0] wrPtr;
		logic [1:0] rdPtr;
		ppc_pkg::ppc_state_t st;
		logic [3:0] cnt;
		logic isRead;
		logic second;
		logic [7:0] txMode;
		logic [7:0] txWait;
		logic [1:0] txMux;
		logic [1:0] txCsf;
		logic prevWr;
		logic prevRd;
		logic irq;
		logic awHeld;
		logic [13:0] awIdx;
		logic wHeld;
		logic [15:0] wData;
		logic [1:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
	} ppc_regs_t;

	ppc_regs_t s_r;
	ppc_regs_t s_nxt;

	// Bits 15 and 13:0 step together; bit 14 may be a chip select and is left alone
	function automatic logic [15:0] stepAddr(input logic [15:0] a, input logic [1:0] m);
		logic [14:0] v;
		v = {a[15], a[13:0]};
		if (m == ppc_pkg::STEP_INC) begin
			v = v + 15'h0001;
		end else if (m == ppc_pkg::STEP_DEC) begin
			v = v - 15'h0001;
		end
		return {v[14], a[14], v[13:0]};
	endfunction

	// Phase length minus one; setup and address phases shrink to one cycle with a zero strobe wait
	function automatic logic [3:0] phaseLen(input ppc_pkg::ppc_state_t p, input logic [7:0] w);
		logic [3:0] sw;
		sw = w[ppc_pkg::WAIT_STROBE +: 4];
		case (p)
			ppc_pkg::PPC_STROBE: phaseLen = sw; // [RULE17]
			ppc_pkg::PPC_HOLD: phaseLen = {2'h0, w[ppc_pkg::WAIT_HOLD +: 2]}; // [RULE18]
			default: phaseLen = (sw == 4'h0) ? 4'h0 : {2'h0, w[ppc_pkg::WAIT_SETUP +: 2]}; // [RULE16]
		endcase
	endfunction

	function automatic ppc_pkg::ppc_state_t dataEntry(input logic [7:0] w);
		dataEntry = (w[ppc_pkg::WAIT_STROBE +: 4] == 4'h0) ? ppc_pkg::PPC_STROBE
			: ppc_pkg::PPC_SETUP; // [RULE19]
	endfunction

	logic on;
	logic halted;
	logic master;
	logic active;
	logic busy;
	logic [1:0] irqMode;
	logic [1:0] stepMode;
	logic [15:0] addrOut;
	logic csLvl;
	logic slaveOn;
	logic wrAct;
	logic rdAct;
	logic wrEv;
	logic rdEv;
	logic doWrite;
	logic endTx;
	logic advance;
	logic [1:0] slot;
	logic [13:0] rIdx;
	ppc_pkg::ppc_state_t nx;

	assign on = s_r.mainCtl[ppc_pkg::MAIN_ON];
	assign halted = s_r.mainCtl[ppc_pkg::MAIN_IDLE] && cpuIdle; // [RULE2]
	assign master = s_r.modeCfg[ppc_pkg::MODE_SEL + 1]; // [RULE15]
	assign active = on && (s_r.st != ppc_pkg::PPC_IDLE);
	assign busy = s_r.st != ppc_pkg::PPC_IDLE; // [RULE9]
	assign irqMode = s_r.modeCfg[ppc_pkg::MODE_IRQ +: 2];
	assign stepMode = s_r.modeCfg[ppc_pkg::MODE_STEP +: 2];
	assign slaveOn = on && !master && !halted;
	// Slave strobe inputs are matched against the same polarity bits as outputs
	assign wrAct = slaveOn && (chipSelectIn == s_r.polCtl[ppc_pkg::POL_CS])
		&& (writeStrobeIn == s_r.polCtl[ppc_pkg::POL_WR]);
	assign rdAct = slaveOn && (chipSelectIn == s_r.polCtl[ppc_pkg::POL_CS])
		&& (readStrobeIn == s_r.polCtl[ppc_pkg::POL_RD]);
	assign wrEv = wrAct && !s_r.prevWr;
	assign rdEv = rdAct && !s_r.prevRd;
	assign slot = (s_r.modeCfg[1:0] == ppc_pkg::MODE_ENH) ? slaveAddrIn
		: ((stepMode == ppc_pkg::STEP_BUF) ? s_r.wrPtr : 2'h0);
	assign doWrite = s_r.awHeld && s_r.wHeld;
	assign rIdx = s_axi_araddr[15:2];

	// Address limited to bits 13:0 while chip select owns pad 14
	assign addrOut = (s_r.txCsf == ppc_pkg::CSF_ON) ? {2'h0, s_r.addr[13:0]} : s_r.addr; // [RULE5]
	assign csLvl = ~((active && s_r.addr[14]) ^ s_r.polCtl[ppc_pkg::POL_CS]); // [RULE6]

	always_comb begin
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		s_nxt.prevWr = wrAct;
		s_nxt.prevRd = rdAct;
		endTx = 1'b0;
		advance = 1'b0;
		nx = ppc_pkg::PPC_IDLE;

		// Register write: address and data may arrive in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.awHeld = 1'b1;
			s_nxt.awIdx = s_axi_awaddr[15:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.wHeld = 1'b1;
			s_nxt.wData = s_axi_wdata[15:0];
			s_nxt.wStrb = s_axi_wstrb[1:0];
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (doWrite) begin
			s_nxt.awHeld = 1'b0;
			s_nxt.wHeld = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = ppc_pkg::RESP_OK;
			if (s_r.wStrb[0]) begin
				case (s_r.awIdx)
					ppc_pkg::IDX_MAIN: s_nxt.mainCtl = s_r.wData[7:0] & ppc_pkg::MAIN_WMASK; // [RULE22]
					ppc_pkg::IDX_POL: s_nxt.polCtl = s_r.wData[7:0] & ppc_pkg::POL_WMASK; // [RULE22]
					ppc_pkg::IDX_MODE: s_nxt.modeCfg = s_r.wData[7:0] & ppc_pkg::MODE_WMASK;
					ppc_pkg::IDX_WAIT: s_nxt.waitCfg = s_r.wData[7:0];
					ppc_pkg::IDX_PAD_HIGH: s_nxt.padEn = s_r.wData[7:0]; // [RULE20]
					ppc_pkg::IDX_DATA: s_nxt.dataOut[7:0] = s_r.wData[7:0];
					ppc_pkg::IDX_ADDR: s_nxt.addr[7:0] = s_r.wData[7:0];
					default: s_nxt.bresp = ppc_pkg::RESP_ERR;
				endcase
			end
			if (s_r.wStrb[1] && s_r.awIdx == ppc_pkg::IDX_DATA) begin
				s_nxt.dataOut[15:8] = s_r.wData[15:8];
			end
			if (s_r.wStrb[1] && s_r.awIdx == ppc_pkg::IDX_ADDR) begin
				s_nxt.addr[15:8] = s_r.wData[15:8];
			end
			if (!(s_r.awIdx inside {ppc_pkg::IDX_MAIN, ppc_pkg::IDX_POL, ppc_pkg::IDX_MODE,
					ppc_pkg::IDX_WAIT, ppc_pkg::IDX_PAD_HIGH, ppc_pkg::IDX_DATA,
					ppc_pkg::IDX_ADDR})) begin
				s_nxt.bresp = ppc_pkg::RESP_ERR;
			end
		end

		// Register read
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = ppc_pkg::RESP_OK;
			s_nxt.rdata = 16'h0000;
			case (rIdx)
				ppc_pkg::IDX_MAIN: s_nxt.rdata[7:0] = s_r.mainCtl;
				ppc_pkg::IDX_POL: s_nxt.rdata[7:0] = s_r.polCtl;
				ppc_pkg::IDX_MODE: s_nxt.rdata[7:0] = {master && busy, s_r.modeCfg[6:0]}; // [RULE9]
				ppc_pkg::IDX_WAIT: s_nxt.rdata[7:0] = s_r.waitCfg;
				ppc_pkg::IDX_PAD_HIGH: s_nxt.rdata[7:0] = s_r.padEn;
				ppc_pkg::IDX_ADDR: s_nxt.rdata = s_r.addr;
				ppc_pkg::IDX_DATA: begin
					if (master) begin
						s_nxt.rdata = s_r.dataIn;
					end else begin
						s_nxt.rdata[7:0] = s_r.inBuf[s_r.rdPtr];
						s_nxt.inFull[s_r.rdPtr] = 1'b0;
						if (stepMode == ppc_pkg::STEP_BUF && s_r.modeCfg[1:0] == ppc_pkg::MODE_LEGACY) begin
							s_nxt.rdPtr = s_r.rdPtr + 2'h1; // [RULE13]
						end
					end
				end
				default: s_nxt.rresp = ppc_pkg::RESP_ERR;
			endcase
		end

		// Slave side: hardware set follows the software clear above, so it wins
		if (wrEv) begin
			s_nxt.inBuf[slot] = portDataPinsIn; // [RULE23]
			s_nxt.inFull[slot] = 1'b1;
			if (s_r.modeCfg[1:0] == ppc_pkg::MODE_LEGACY && stepMode == ppc_pkg::STEP_BUF) begin
				s_nxt.wrPtr = s_r.wrPtr + 2'h1; // [RULE13]
			end
		end
		if ((wrEv || rdEv) && ((irqMode == ppc_pkg::IRQ_EACH)
				|| (irqMode == ppc_pkg::IRQ_BUF3 && slot == ppc_pkg::BUF_LAST))) begin
			s_nxt.irq = 1'b1; // [RULE10] [RULE11]
		end

		// Master transfer start; a busy port ignores the access
		if (on && master && !busy && !halted) begin
			if ((doWrite && s_r.awIdx == ppc_pkg::IDX_DATA)
					|| (s_axi_arvalid && s_axi_arready && rIdx == ppc_pkg::IDX_DATA)) begin
				s_nxt.isRead = !(doWrite && s_r.awIdx == ppc_pkg::IDX_DATA);
				s_nxt.txMode = s_r.modeCfg; // [RULE24]
				s_nxt.txWait = s_r.waitCfg;
				s_nxt.txMux = s_r.mainCtl[ppc_pkg::MAIN_MUX +: 2];
				s_nxt.txCsf = s_r.polCtl[ppc_pkg::POL_CSF +: 2];
				s_nxt.second = 1'b0;
				nx = (s_r.mainCtl[ppc_pkg::MAIN_MUX +: 2] == ppc_pkg::MUX_SEP)
					? dataEntry(s_r.waitCfg) : ppc_pkg::PPC_ADDR_LO; // [RULE3]
				s_nxt.st = nx;
				s_nxt.cnt = phaseLen(nx, s_r.waitCfg);
			end
		end

		// Sequencer; frozen while halted in idle
		if (busy && !halted) begin
			if (s_r.cnt != 4'h0) begin
				s_nxt.cnt = s_r.cnt - 4'h1;
			end else begin
				advance = 1'b1;
				case (s_r.st)
					ppc_pkg::PPC_ADDR_LO: nx = (s_r.txMux == ppc_pkg::MUX_FULL)
						? ppc_pkg::PPC_ADDR_HI : dataEntry(s_r.txWait); // [RULE3]
					ppc_pkg::PPC_ADDR_HI: nx = dataEntry(s_r.txWait);
					ppc_pkg::PPC_SETUP: nx = ppc_pkg::PPC_STROBE;
					ppc_pkg::PPC_STROBE: begin
						if (s_r.isRead) begin
							if (s_r.second) begin
								s_nxt.dataIn[15:8] = portDataPinsIn;
							end else begin
								s_nxt.dataIn[7:0] = portDataPinsIn;
							end
						end
						if (s_r.txWait[ppc_pkg::WAIT_STROBE +: 4] != 4'h0) begin
							nx = ppc_pkg::PPC_HOLD; // [RULE19]
						end else begin
							endTx = 1'b1;
						end
					end
					ppc_pkg::PPC_HOLD: endTx = 1'b1;
					default: nx = ppc_pkg::PPC_IDLE;
				endcase
				if (endTx && s_r.txMode[ppc_pkg::MODE_WIDE] && !s_r.second) begin
					s_nxt.second = 1'b1; // [RULE14]
					nx = dataEntry(s_r.txWait);
					endTx = 1'b0;
				end
				if (endTx) begin
					s_nxt.addr = stepAddr(s_r.addr, s_r.txMode[ppc_pkg::MODE_STEP +: 2]); // [RULE12]
					s_nxt.irq = (s_r.txMode[ppc_pkg::MODE_IRQ +: 2] == ppc_pkg::IRQ_EACH); // [RULE11]
				end
				s_nxt.st = nx;
				s_nxt.cnt = phaseLen(nx, s_r.txWait);
			end
		end

		if (!on) begin
			s_nxt.st = ppc_pkg::PPC_IDLE; // [RULE1]
			s_nxt.cnt = 4'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0; // [RULE21]
		end else begin
			s_r <= s_nxt;
		end
	end

	// Bus handshakes
	assign s_axi_awready = !s_r.awHeld && !s_r.bvalid;
	assign s_axi_wready = !s_r.wHeld && !s_r.bvalid;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = {16'h0000, s_r.rdata};
	assign s_axi_rresp = s_r.rresp;
	assign portIrq = s_r.irq;
	assign cpuStall = busy && (s_r.txMode[ppc_pkg::MODE_IRQ +: 2] == ppc_pkg::IRQ_STALL); // [RULE11]

	// Pad drive
	always_comb begin
		portDataPinsOut = s_r.addr[7:0];
		if (s_r.st == ppc_pkg::PPC_ADDR_LO) begin
			portDataPinsOut = addrOut[7:0]; // [RULE3]
		end else if (s_r.st == ppc_pkg::PPC_ADDR_HI) begin
			portDataPinsOut = addrOut[15:8];
		end else if (master) begin
			portDataPinsOut = s_r.second ? s_r.dataOut[15:8] : s_r.dataOut[7:0];
		end
		portDataPinsOe = (active && (!s_r.isRead || s_r.st == ppc_pkg::PPC_ADDR_LO
			|| s_r.st == ppc_pkg::PPC_ADDR_HI)) || rdAct; // [RULE1]
		portAddressPinsOut = {addrOut[15],
			(s_r.txCsf == ppc_pkg::CSF_ON) ? csLvl : addrOut[14], addrOut[13:8]}; // [RULE8]
		portAddressPinsOe = (on && master) ? s_r.padEn : 8'h00; // [RULE20]
		if (s_r.txMode[1:0] == ppc_pkg::MODE_MASTER1) begin
			writeStrobeOut = ~((active && s_r.st == ppc_pkg::PPC_STROBE)
				^ s_r.polCtl[ppc_pkg::POL_WR]); // [RULE7]
			readStrobeOut = ~((active && s_r.isRead) ^ s_r.polCtl[ppc_pkg::POL_RD]);
		end else begin
			writeStrobeOut = ~((active && s_r.st == ppc_pkg::PPC_STROBE && !s_r.isRead)
				^ s_r.polCtl[ppc_pkg::POL_WR]); // [RULE7]
			readStrobeOut = ~((active && s_r.st == ppc_pkg::PPC_STROBE && s_r.isRead)
				^ s_r.polCtl[ppc_pkg::POL_RD]);
		end
		writeStrobeOe = on && master && s_r.mainCtl[ppc_pkg::MAIN_WR_ON]; // [RULE4]
		readStrobeOe = on && master && s_r.mainCtl[ppc_pkg::MAIN_RD_ON];
		byteEnableOut = ~((active && s_r.txMode[ppc_pkg::MODE_WIDE])
			^ s_r.polCtl[ppc_pkg::POL_BE]); // [RULE6]
		byteEnableOe = on && master && s_r.mainCtl[ppc_pkg::MAIN_BE_ON]; // [RULE4]
		if (s_r.txMux == ppc_pkg::MUX_SEP) begin
			addrLatchLowStrobe = s_r.addr[0]; // [RULE8]
			addrLatchHighStrobe = s_r.addr[1];
		end else begin
			addrLatchLowStrobe = ~((active && s_r.st == ppc_pkg::PPC_ADDR_LO)
				^ s_r.polCtl[ppc_pkg::POL_AL]); // [RULE6]
			addrLatchHighStrobe = ~((active && s_r.st == ppc_pkg::PPC_ADDR_HI)
				^ s_r.polCtl[ppc_pkg::POL_AL]);
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_off_idle: assert property (!on |=> s_r.st == ppc_pkg::PPC_IDLE) // [RULE1]
		else $error("port not idle after disable");
	a_halt_freeze: assert property (on && halted && busy |=> $stable(s_r.st) && $stable(s_r.cnt)) // [RULE2]
		else $error("sequencer moved while halted");
	a_mux_high: assert property (on && !halted && s_r.st == ppc_pkg::PPC_ADDR_LO && s_r.cnt == 4'h0 // [RULE3]
		&& s_r.txMux == ppc_pkg::MUX_FULL |=> s_r.st == ppc_pkg::PPC_ADDR_HI)
		else $error("high address phase missing");
	a_strobe_len: assert property ($rose(s_r.st == ppc_pkg::PPC_STROBE) // [RULE17]
		|-> s_r.cnt == s_r.txWait[5:2])
		else $error("strobe length wrong");
	a_setup_skip: assert property (s_r.st == ppc_pkg::PPC_SETUP || s_r.st == ppc_pkg::PPC_HOLD // [RULE19]
		|-> s_r.txWait[5:2] != 4'h0)
		else $error("setup or hold with zero strobe wait");
	a_busy_master: assert property (busy |-> s_r.txMode[1]) // [RULE9]
		else $error("busy outside master mode");
	a_step_inc: assert property (endTx && s_r.txMode[4:3] == ppc_pkg::STEP_INC // [RULE12]
		&& !(doWrite && s_r.awIdx == ppc_pkg::IDX_ADDR)
		|=> s_r.addr[13:0] == $past(s_r.addr[13:0]) + 14'h0001)
		else $error("address not incremented");
	a_slave_cap: assert property (wrEv && s_r.modeCfg[1:0] == ppc_pkg::MODE_LEGACY // [RULE23]
		&& s_r.modeCfg[4:3] != ppc_pkg::STEP_BUF |=> s_r.inBuf[0] == $past(portDataPinsIn)
		&& s_r.inFull[0])
		else $error("slave byte not captured");
	a_irq_each: assert property (endTx && s_r.txMode[6:5] == ppc_pkg::IRQ_EACH |=> portIrq) // [RULE11]
		else $error("end of cycle interrupt missing");
	a_reserved_zero: assert property (!s_r.polCtl[4] && !s_r.mainCtl[6]) // [RULE22]
		else $error("reserved bit set");
endmodule

// ==== tb/ppc_ext_model.sv ====
// External parallel peripheral and host driving the port pins
`timescale 1ns/100ps
module ppc_ext_model (
	input wire logic sys_clk,
	input wire logic [7:0] devData,
	input wire logic devDataOe,
	input wire logic wrOut,
	input wire logic wrOe,
	input wire logic rdOut,
	input wire logic rdOe,
	output logic [7:0] pinData,
	output logic csPin,
	output logic wrPin,
	output logic rdPin
);
	logic [7:0] readByte = 8'h00;
	logic [7:0] noise = 8'h5a;
	logic [7:0] hostByte = 8'h00;
	logic hostDrive = 1'b0;
	logic [15:0] wrLog = 16'h0000;
	logic [15:0] strobeCnt = 16'h0000;
	initial begin
		csPin = 1'b1;
		wrPin = 1'b1;
		rdPin = 1'b1;
	end
	// Undriven lines toggle so a stale byte can never pass for real data
	assign pinData = (rdOe && !rdOut) ? readByte : (hostDrive ? hostByte : noise);
	always @(posedge sys_clk) begin
		noise <= ~noise;
		if (wrOe && !wrOut && devDataOe) begin
			strobeCnt <= strobeCnt + 16'h0001;
			wrLog <= {devData, wrLog[15:8]};
		end
	end
	// Active-low chip select and write strobe around a held byte
	task automatic hostWrite(input logic [7:0] b);
		@(posedge sys_clk);
		hostByte <= b;
		hostDrive <= 1'b1;
		csPin <= 1'b0;
		@(posedge sys_clk);
		wrPin <= 1'b0;
		repeat (2) @(posedge sys_clk);
		wrPin <= 1'b1;
		@(posedge sys_clk);
		csPin <= 1'b1;
		hostDrive <= 1'b0;
	endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the parallel port controller
`timescale 1ns/100ps
module testbench;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'h3;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, cpuIdle = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, slaveAddrIn = 2'h0;
	logic [31:0] s_axi_rdata;
	logic [7:0] portDataPinsIn, portDataPinsOut, portAddressPinsOe;
	logic portDataPinsOe, chipSelectIn, writeStrobeIn, writeStrobeOut, writeStrobeOe;
	logic readStrobeIn, readStrobeOut, readStrobeOe, portIrq;
	logic byteEnableOut, byteEnableOe, cpuStall;
	logic [15:0] rv, irqCnt = 16'h0000;
	int n_errors = 0, n_compared = 0;
	logic [13:0] regIdx [5] = '{ppc_pkg::IDX_PAD_HIGH, ppc_pkg::IDX_WAIT, ppc_pkg::IDX_MODE,
		ppc_pkg::IDX_POL, ppc_pkg::IDX_MAIN};
	logic [15:0] rdMask [5] = '{16'h00ff, 16'h00ff, 16'h007f, 16'h00ef, 16'h00bf};
	always #25 sys_clk = ~sys_clk;
	ppc_port_ctrl dut (
		.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .cpuIdle, .portDataPinsIn, .portDataPinsOut, .portDataPinsOe,
		.portAddressPinsOut(), .portAddressPinsOe, .slaveAddrIn, .chipSelectIn, .writeStrobeIn,
		.writeStrobeOut, .writeStrobeOe, .readStrobeIn, .readStrobeOut, .readStrobeOe,
		.byteEnableOut, .byteEnableOe, .addrLatchLowStrobe(), .addrLatchHighStrobe(),
		.portIrq, .cpuStall
	);
	ppc_ext_model model (
		.sys_clk, .devData(portDataPinsOut), .devDataOe(portDataPinsOe), .wrOut(writeStrobeOut),
		.wrOe(writeStrobeOe), .rdOut(readStrobeOut), .rdOe(readStrobeOe), .pinData(portDataPinsIn),
		.csPin(chipSelectIn), .wrPin(writeStrobeIn), .rdPin(readStrobeIn)
	);
	always @(posedge sys_clk) begin
		if (portIrq === 1'b1) irqCnt <= irqCnt + 16'h0001;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// Each channel is released only at the edge where its ready was seen high
	task automatic wr(input logic [13:0] idx, input logic [15:0] d,
		input logic [1:0] er = ppc_pkg::RESP_OK);
		logic a, w, b, ta, tw;
		logic [1:0] resp;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		a = 1'b1;
		w = 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge sys_clk);
			ta = a && s_axi_awready;
			tw = w && s_axi_wready;
			b = !a && !w && s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge sys_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			a = a && !ta;
			w = w && !tw;
		end
		check("write response", {14'h0000, resp}, {14'h0000, er});
	endtask
	task automatic rd(input logic [13:0] idx, output logic [15:0] d, output logic [1:0] resp);
		logic a, ta, done;
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		a = 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge sys_clk);
			done = !a && s_axi_rvalid;
			d = s_axi_rdata[15:0];
			resp = s_axi_rresp;
			ta = a && s_axi_arready;
			@(posedge sys_clk);
			if (ta) s_axi_arvalid <= 1'b0;
			a = a && !ta;
		end
	endtask
	task automatic rdChk(input string what, input logic [13:0] idx, input logic [15:0] exp,
		input logic [1:0] er = ppc_pkg::RESP_OK);
		logic [15:0] v;
		logic [1:0] r;
		rd(idx, v, r);
		check("read response", {14'h0000, r}, {14'h0000, er});
		if (er === ppc_pkg::RESP_OK) check(what, v, exp);
	endtask
	task automatic waitIdle();
		logic [15:0] v;
		logic [1:0] r;
		v = 16'h0080;
		for (int i = 0; i < 40 && v[7] !== 1'b0; i++) rd(ppc_pkg::IDX_MODE, v, r);
		check("busy flag", v & 16'h0080, 16'h0000);
	endtask
	task automatic summarize();
		$display("errors %0d comparisons %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 5; i++) rdChk("reset value", regIdx[i], 16'h0000);
		for (int i = 0; i < 5; i++) wr(regIdx[i], 16'h00ff);
		for (int i = 0; i < 5; i++) rdChk("stored bits", regIdx[i], rdMask[i]);
		for (int i = 0; i < 5; i++) wr(regIdx[i], 16'h0000);
		wr(14'h0f58, 16'h0001, ppc_pkg::RESP_ERR);
		rdChk("unmapped", 14'h0f58, 16'h0000, ppc_pkg::RESP_ERR);
		// Transfers requested while off or halted must never reach the pins
		wr(ppc_pkg::IDX_MODE, 16'h0022);
		wr(ppc_pkg::IDX_MAIN, 16'h0003);
		wr(ppc_pkg::IDX_DATA, 16'h0011);
		repeat (10) @(posedge sys_clk);
		check("strobes while off", model.strobeCnt, 16'h0000);
		cpuIdle <= 1'b1;
		wr(ppc_pkg::IDX_MAIN, 16'h00a3);
		wr(ppc_pkg::IDX_DATA, 16'h0022);
		repeat (10) @(posedge sys_clk);
		check("strobes while halted", model.strobeCnt, 16'h0000);
		cpuIdle <= 1'b0;
		wr(ppc_pkg::IDX_MAIN, 16'h0083);
		wr(ppc_pkg::IDX_MODE, 16'h002a);
		wr(ppc_pkg::IDX_ADDR, 16'h0010);
		wr(ppc_pkg::IDX_PAD_HIGH, 16'h003f);
		check("address pads", {8'h00, portAddressPinsOe}, 16'h003f);
		wr(ppc_pkg::IDX_DATA, 16'h005a);
		waitIdle();
		check("strobe cycles", model.strobeCnt, 16'h0001);
		check("byte written", {8'h00, model.wrLog[15:8]}, 16'h005a);
		check("end interrupts", irqCnt, 16'h0001);
		wr(ppc_pkg::IDX_MODE, 16'h004a);
		wr(ppc_pkg::IDX_WAIT, 16'h004e);
		wr(ppc_pkg::IDX_DATA, 16'h00a5);
		check("stall during transfer", {15'h0000, cpuStall}, 16'h0001);
		rdChk("busy during transfer", ppc_pkg::IDX_MODE, 16'h00ca);
		waitIdle();
		check("stall after transfer", {15'h0000, cpuStall}, 16'h0000);
		check("long strobe cycles", model.strobeCnt, 16'h0005);
		rdChk("stepped address", ppc_pkg::IDX_ADDR, 16'h0012);
		wr(ppc_pkg::IDX_WAIT, 16'h0000);
		wr(ppc_pkg::IDX_POL, 16'h0002);
		check("write strobe idle", {15'h0000, writeStrobeOut}, 16'h0000);
		wr(ppc_pkg::IDX_POL, 16'h0000);
		model.readByte <= 8'h3c;
		wr(ppc_pkg::IDX_MODE, 16'h0032);
		rd(ppc_pkg::IDX_DATA, rv, rr);
		waitIdle();
		rdChk("stepped down address", ppc_pkg::IDX_ADDR, 16'h0011);
		rd(ppc_pkg::IDX_DATA, rv, rr);
		check("byte read", {8'h00, rv[7:0]}, 16'h003c);
		waitIdle();
		wr(ppc_pkg::IDX_MAIN, 16'h0087);
		wr(ppc_pkg::IDX_MODE, 16'h0006);
		wr(ppc_pkg::IDX_DATA, 16'hbeef);
		check("byte enable", {14'h0000, byteEnableOe, byteEnableOut}, 16'h0002);
		waitIdle();
		check("wide strobes", model.strobeCnt, 16'h0007);
		check("wide bytes", model.wrLog, 16'hbeef);
		wr(ppc_pkg::IDX_MODE, 16'h0000);
		model.hostWrite(8'hc3);
		rd(ppc_pkg::IDX_DATA, rv, rr);
		check("captured byte", {8'h00, rv[7:0]}, 16'h00c3);
		summarize();
	end
endmodule
